// ### rtl/rcsl_defines.svh
`ifndef RCSL_DEFINES_SVH
`define RCSL_DEFINES_SVH

`define RCSL_CLK_HZ          125000000
`define RCSL_BAUD_DEFAULT    9600
`define RCSL_TIMEOUT_MS      2000
`define RCSL_TIMEOUT_CYCLES  ((`RCSL_CLK_HZ / 1000) * `RCSL_TIMEOUT_MS)
`define RCSL_DATA_BITS       8
`define RCSL_MSG_BYTES       2
`define RCSL_FIFO_DEPTH      16
`define RCSL_TXOFF_BIT       0
`define RCSL_ILOCK_BIT       1
`define RCSL_LAMP_BIT        7

`endif

// ### rtl/rcsl_pkg.sv
package rcsl_pkg;
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } rcsl_msg_t;

  typedef enum logic [3:0] {
    RCSL_IDLE  = 4'b0001,
    RCSL_START = 4'b0010,
    RCSL_DATA  = 4'b0100,
    RCSL_STOP  = 4'b1000
  } rcsl_ser_t;
endpackage

// ### rtl/rcsl_fifo.sv
`timescale 1ns/1ps
module rcsl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,   // system clock
  input  wire logic             rst,       // async reset
  input  wire logic [WIDTH-1:0] in_data,   // write word
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // not full
  output logic      [WIDTH-1:0] out_data,  // head word
  output logic                  out_valid, // not empty
  input  wire logic             out_ready  // reader takes head
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign in_ready  = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
  assign out_valid = (wp_q != rp_q);
  assign out_data  = mem_q[rp_q[AW-1:0]];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (push) mem_q[wp_q[AW-1:0]] <= in_data;
  end
endmodule

// ### rtl/rcsl_top.sv
// Summary of operation
// RQ1: carry data between station and remote unit
// RQ2: send parallel data as two-byte message
// RQ3: start, eight data, odd parity, stop
// RQ4: receive line into two-byte parallel message
// RQ5: accept only two identical consecutive messages
// RQ6: accepted message updates latch, pulses once
// RQ7: supervise accepted messages and carrier detect
// RQ8: two seconds missing gives timeout
// RQ9: timeout forces transmitter-off when enabled
// RQ10: timeout forces interlock when enabled
// RQ11: standby lamp status goes in sent data
// RQ12: bad parity or stop discards character
`timescale 1ns/1ps
`include "rcsl_defines.svh"
module rcsl_top #(
  parameter int BAUD_DIV    = `RCSL_CLK_HZ / `RCSL_BAUD_DEFAULT,
  parameter int TIMEOUT_CYC = `RCSL_TIMEOUT_CYCLES,
  parameter int FIFO_DEPTH  = `RCSL_FIFO_DEPTH
) (
  input  wire logic              clk_sys,         // 125 MHz clock
  input  wire logic              rst,             // async reset
  input  wire rcsl_pkg::rcsl_msg_t tx_msg,        // station data to send
  input  wire logic              tx_valid,        // station offers a message
  output logic                   tx_ready_q,      // fifo has room
  input  wire logic              standby_lamp,    // standby lamp status in
  output logic                   serial_out_line, // serial line to remote
  input  wire logic              serial_in_line,  // serial line from remote
  input  wire logic              carrier_detect,  // line carrier present
  input  wire logic              cfg_force_txoff, // enable forced tx-off
  input  wire logic              cfg_force_ilock, // enable forced interlock
  output rcsl_pkg::rcsl_msg_t    rx_msg_q,        // filtered received data
  output logic                   new_msg_q,       // one-cycle new-message pulse
  output logic                   timeout_q,       // supervision timeout
  output logic                   txoff_q,         // transmitter-off command
  output logic                   ilock_q          // interlock command
);
  localparam int BW = $clog2(BAUD_DIV + 1);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  initial begin
    if (BAUD_DIV < 16) $error("baud divider too small");
    if (TIMEOUT_CYC < 1) $error("timeout must be positive");
  end

  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ~^b;
  endfunction

  // ---------------- transmit path ----------------
  logic [15:0] f_out;
  logic        f_valid;
  logic        f_ready;
  logic        f_in_ready;
  wire  [15:0] tx_word = {tx_msg.hi, tx_msg.lo};
  rcsl_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (tx_word),
    .in_valid  (tx_valid),
    .in_ready  (f_in_ready),
    .out_data  (f_out),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  rcsl_pkg::rcsl_ser_t tst_q;
  logic [BW-1:0]  tbaud_q;
  logic [3:0]     tbit_q;
  logic [9:0]     tsh_q;
  logic [7:0]     thi_q;
  logic           tbyte_q;
  wire            ttick = (tbaud_q == BW'(BAUD_DIV - 1));
  // standby lamp rides in the top bit of the second byte
  wire [7:0]      lamp_hi = {standby_lamp, f_out[14:8]}; // RQ11
  assign f_ready = (tst_q == rcsl_pkg::RCSL_IDLE) && !tbyte_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) tx_ready_q <= 1'b0;
    else tx_ready_q <= f_in_ready;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tst_q           <= rcsl_pkg::RCSL_IDLE;
      tbaud_q         <= '0;
      tbit_q          <= 4'h0;
      tsh_q           <= 10'h3FF;
      thi_q           <= 8'h00;
      tbyte_q         <= 1'b0;
      serial_out_line <= 1'b1;
    end else begin
      tbaud_q <= (tst_q == rcsl_pkg::RCSL_IDLE || ttick) ? '0 : tbaud_q + 1'b1;
      case (tst_q)
        rcsl_pkg::RCSL_IDLE: begin
          serial_out_line <= 1'b1;
          // a pending hi byte goes first, or a queued word would cut the message in half
          if (tbyte_q) begin
            tsh_q   <= {1'b1, odd_par(thi_q), thi_q};
            tbyte_q <= 1'b0;
            tst_q   <= rcsl_pkg::RCSL_START;
          end else if (f_valid) begin // RQ2
            tsh_q   <= {1'b1, odd_par(f_out[7:0]), f_out[7:0]}; // RQ3
            thi_q   <= lamp_hi;
            tbyte_q <= 1'b1;
            tst_q   <= rcsl_pkg::RCSL_START;
          end
        end
        rcsl_pkg::RCSL_START: begin
          serial_out_line <= 1'b0;
          if (ttick) begin
            tbit_q <= 4'h0;
            tst_q  <= rcsl_pkg::RCSL_DATA;
          end
        end
        rcsl_pkg::RCSL_DATA: begin
          serial_out_line <= tsh_q[0];
          if (ttick) begin
            tsh_q  <= {1'b1, tsh_q[9:1]};
            tbit_q <= tbit_q + 4'h1;
            if (tbit_q == 4'h9) tst_q <= rcsl_pkg::RCSL_IDLE; // 8 data, parity, stop
          end
        end
        default: tst_q <= rcsl_pkg::RCSL_IDLE;
      endcase
    end
  end

  // ---------------- receive path ----------------
  rcsl_pkg::rcsl_ser_t rst_q;
  logic [BW-1:0] rbaud_q;
  logic [3:0]    rbit_q;
  logic [9:0]    rsh_q;
  logic          rbyte_q;
  logic [7:0]    rlo_q;
  logic          rmsg_v_q;
  logic [15:0]   rmsg_q;
  logic [15:0]   prev_q;
  logic          prev_v_q;
  logic          in_d_q;
  wire           rtick = (rbaud_q == BW'(BAUD_DIV - 1));
  wire           rmid  = (rbaud_q == BW'(BAUD_DIV / 2));
  wire [7:0]     rdat  = rsh_q[8:1];
  // rsh_q holds {stop, parity, d7..d0} after the last shift
  wire           char_ok = rsh_q[9] && (rsh_q[8] == odd_par(rsh_q[7:0])); // RQ12

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_d_q   <= 1'b1;
      rst_q    <= rcsl_pkg::RCSL_IDLE;
      rbaud_q  <= '0;
      rbit_q   <= 4'h0;
      rsh_q    <= 10'h000;
      rbyte_q  <= 1'b0;
      rlo_q    <= 8'h00;
      rmsg_v_q <= 1'b0;
      rmsg_q   <= 16'h0000;
    end else begin
      in_d_q   <= serial_in_line;
      rmsg_v_q <= 1'b0;
      rbaud_q  <= (rst_q == rcsl_pkg::RCSL_IDLE || rtick) ? '0 : rbaud_q + 1'b1;
      case (rst_q)
        rcsl_pkg::RCSL_IDLE: begin
          if (!in_d_q) rst_q <= rcsl_pkg::RCSL_START;
        end
        rcsl_pkg::RCSL_START: begin
          if (rmid && in_d_q) rst_q <= rcsl_pkg::RCSL_IDLE; // glitch, not a start
          else if (rtick) begin
            rbit_q <= 4'h0;
            rst_q  <= rcsl_pkg::RCSL_DATA;
          end
        end
        rcsl_pkg::RCSL_DATA: begin
          if (rmid) begin
            rsh_q  <= {in_d_q, rsh_q[9:1]};
            rbit_q <= rbit_q + 4'h1;
          end
          if (rtick && rbit_q == 4'hA) rst_q <= rcsl_pkg::RCSL_STOP;
        end
        rcsl_pkg::RCSL_STOP: begin
          rst_q <= rcsl_pkg::RCSL_IDLE;
          if (!char_ok) begin
            rbyte_q <= 1'b0; // bad char drops the partial message
          end else if (!rbyte_q) begin
            rlo_q   <= rsh_q[7:0];
            rbyte_q <= 1'b1;
          end else begin
            rmsg_q   <= {rsh_q[7:0], rlo_q}; // RQ4
            rmsg_v_q <= 1'b1;
            rbyte_q  <= 1'b0;
          end
        end
        default: rst_q <= rcsl_pkg::RCSL_IDLE;
      endcase
    end
  end

  // ---------------- message detector ----------------
  wire match = rmsg_v_q && prev_v_q && (rmsg_q == prev_q); // RQ5
  logic [15:0] latch_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_q    <= 16'h0000;
      prev_v_q  <= 1'b0;
      latch_q   <= 16'h0000;
      new_msg_q <= 1'b0;
    end else begin
      new_msg_q <= match; // RQ6
      if (rmsg_v_q) begin
        prev_q   <= rmsg_q;
        // a pair is used once; a third copy starts a new pair
        prev_v_q <= !match;
      end
      if (match) latch_q <= rmsg_q; // RQ6
    end
  end

  // ---------------- supervision timer ----------------
  logic [TW-1:0] cd_q;
  wire  cd_lost = (cd_q >= TW'(TIMEOUT_CYC - 1));
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) cd_q <= '0;
    else if (carrier_detect) cd_q <= '0;
    else if (!cd_lost) cd_q <= cd_q + 1'b1; // RQ8
  end
  logic [TW-1:0] tmr_q;
  wire  restart  = match || !carrier_detect; // RQ7
  wire  expired  = (tmr_q >= TW'(TIMEOUT_CYC - 1));
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tmr_q     <= '0;
      timeout_q <= 1'b0;
    end else begin
      if (match) tmr_q <= '0;
      else if (!expired) tmr_q <= tmr_q + 1'b1;
      // carrier loss for the full span times out just like missing messages
      timeout_q <= expired || cd_lost; // RQ8
    end
  end

  // ---------------- data filter ----------------
  wire tout = expired || cd_lost; // RQ8
  wire [15:0] filt = latch_q
                   | ({15'h0000, tout && cfg_force_txoff} << `RCSL_TXOFF_BIT)  // RQ9
                   | ({15'h0000, tout && cfg_force_ilock} << `RCSL_ILOCK_BIT); // RQ10
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_msg_q <= '0;
      txoff_q  <= 1'b0;
      ilock_q  <= 1'b0;
    end else begin
      rx_msg_q <= filt; // RQ1
      txoff_q  <= filt[`RCSL_TXOFF_BIT];
      ilock_q  <= filt[`RCSL_ILOCK_BIT];
    end
  end
  wire unused_ok = restart ^ rdat[0];
endmodule

// ### bench/rcsl_monitor.sv
`timescale 1ns/1ps
module rcsl_monitor #(
  parameter int BAUD_DIV    = 16,
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic clk_sys,         // clock
  input wire logic rst,             // async reset
  input wire logic tx_ready_q,      // fifo room
  input wire logic serial_out_line, // line to remote
  input wire logic carrier_detect,  // carrier present
  input wire logic cfg_force_txoff, // tx-off force enable
  input wire logic cfg_force_ilock, // interlock force enable
  input wire logic new_msg_q,       // accept pulse
  input wire logic timeout_q,       // supervision timeout
  input wire logic txoff_q,         // tx-off command
  input wire logic ilock_q          // interlock command
);
  int   fc_q;
  int   msg_cnt_q;
  int   nc_cnt_q;
  logic par_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // frame tracker re-arms at mid stop so a back-to-back start is not missed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fc_q <= 0;
      msg_cnt_q <= 0;
      nc_cnt_q <= 0;
      par_q <= 1'b0;
    end else begin
      if (fc_q == 0) fc_q <= serial_out_line ? 0 : 1;
      else fc_q <= (fc_q == 10 * BAUD_DIV + BAUD_DIV / 2) ? 0 : fc_q + 1;
      if (fc_q == 1) par_q <= 1'b0;
      else if (fc_q % BAUD_DIV == BAUD_DIV / 2 && fc_q > BAUD_DIV && fc_q < 10 * BAUD_DIV) par_q <= par_q ^ serial_out_line;
      msg_cnt_q <= new_msg_q ? 0 : (msg_cnt_q < TIMEOUT_CYC + 8 ? msg_cnt_q + 1 : msg_cnt_q);
      nc_cnt_q <= carrier_detect ? 0 : (nc_cnt_q < TIMEOUT_CYC + 8 ? nc_cnt_q + 1 : nc_cnt_q);
    end
  end
  sequence s_frame_start;
    fc_q == 1;
  endsequence
  sequence s_forced(en);
    (timeout_q && en)[*3];
  endsequence
  a_start_low: assert property (s_frame_start |-> !serial_out_line[*8]) else $error("start bit too short");
  a_stop_high: assert property (fc_q == 10 * BAUD_DIV + 2 |-> serial_out_line) else $error("stop bit not high");
  a_odd_parity: assert property (fc_q == 10 * BAUD_DIV |-> par_q) else $error("parity not odd");
  a_pulse_single: assert property (new_msg_q |=> !new_msg_q) else $error("new message pulse too long");
  a_timeout_nomsg: assert property (msg_cnt_q >= TIMEOUT_CYC + 4 |-> timeout_q) else $error("no timeout on silence");
  a_timeout_nocar: assert property (nc_cnt_q >= TIMEOUT_CYC + 4 |-> timeout_q) else $error("no timeout on carrier loss");
  a_force_txoff: assert property (s_forced(cfg_force_txoff) |-> txoff_q) else $error("tx-off not forced");
  a_force_ilock: assert property (s_forced(cfg_force_ilock) |-> ilock_q) else $error("interlock not forced");
  a_ready_reset: assert property ($fell(rst) |-> ##[1:3] tx_ready_q) else $error("fifo not ready after reset");
endmodule
bind rcsl_top rcsl_monitor #(.BAUD_DIV(BAUD_DIV), .TIMEOUT_CYC(TIMEOUT_CYC)) mon (.clk_sys(clk_sys), .rst(rst),
  .tx_ready_q(tx_ready_q), .serial_out_line(serial_out_line), .carrier_detect(carrier_detect),
  .cfg_force_txoff(cfg_force_txoff), .cfg_force_ilock(cfg_force_ilock), .new_msg_q(new_msg_q),
  .timeout_q(timeout_q), .txoff_q(txoff_q), .ilock_q(ilock_q));

// ### bench/rcsl_remote.sv
`timescale 1ns/1ps
module rcsl_remote #(
  parameter int B = 16
) (
  input  wire logic clk_sys,      // clock
  output logic      line_to_dut,  // serial into device
  input  wire logic line_from_dut // serial from device
);
  rcsl_pkg::rcsl_msg_t rxq[$];
  int                  bad_cnt = 0;
  logic [9:0]          f;
  logic [7:0]          lo_b;
  logic                have_lo = 1'b0;
  initial line_to_dut = 1'b1;
  task automatic send_char(input logic [7:0] d, input logic bad);
    logic [10:0] w;
    w = {1'b1, ~^d ^ bad, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_to_dut = w[i];
      repeat (B) @(negedge clk_sys);
    end
  endtask
  task automatic send_msg(input rcsl_pkg::rcsl_msg_t m, input logic bad);
    send_char(m.lo, 1'b0);
    send_char(m.hi, bad);
  endtask
  // samples mid-bit; the stop sample is taken early so the next start edge is seen
  always begin
    @(negedge line_from_dut);
    repeat (B / 2) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      repeat (B) @(posedge clk_sys);
      f[i] = line_from_dut;
    end
    if (!f[9] || !(^f[8:0])) bad_cnt++;
    else if (have_lo) begin
      rxq.push_back({f[7:0], lo_b});
      have_lo = 1'b0;
    end else begin
      lo_b = f[7:0];
      have_lo = 1'b1;
    end
  end
endmodule

// ### bench/tb_rcsl_top.sv
`timescale 1ns/1ps
module tb_rcsl_top;
  localparam int B  = 16;
  localparam int TO = 2000;
  typedef struct packed {
    rcsl_pkg::rcsl_msg_t m;
    logic                lamp;
    rcsl_pkg::rcsl_msg_t exp_tx;
  } rcsl_row_t;
  logic                clk_sys;
  logic                rst;
  logic                tx_valid;
  logic                standby_lamp;
  logic                carrier_detect;
  logic                cfg_force_txoff;
  logic                cfg_force_ilock;
  logic                tx_ready_q;
  logic                serial_out_line;
  logic                serial_in_line;
  logic                new_msg_q;
  logic                timeout_q;
  logic                txoff_q;
  logic                ilock_q;
  rcsl_pkg::rcsl_msg_t tx_msg;
  rcsl_pkg::rcsl_msg_t rx_msg_q;
  int                  err_count = 0;
  int                  n_compared = 0;
  int                  pulses = 0;
  int                  p;
  int                  n;
  rcsl_row_t           rows[4] = '{'{16'hFFFF, 1'b0, 16'h7FFF}, '{16'h80FD, 1'b0, 16'h00FD},
                                   '{16'h4A02, 1'b1, 16'hCA02}, '{16'h3C01, 1'b1, 16'hBC01}};
  rcsl_top #(.BAUD_DIV(B), .TIMEOUT_CYC(TO)) uut (.clk_sys(clk_sys), .rst(rst), .tx_msg(tx_msg),
    .tx_valid(tx_valid), .tx_ready_q(tx_ready_q), .standby_lamp(standby_lamp), .serial_out_line(serial_out_line),
    .serial_in_line(serial_in_line), .carrier_detect(carrier_detect), .cfg_force_txoff(cfg_force_txoff),
    .cfg_force_ilock(cfg_force_ilock), .rx_msg_q(rx_msg_q), .new_msg_q(new_msg_q), .timeout_q(timeout_q),
    .txoff_q(txoff_q), .ilock_q(ilock_q));
  rcsl_remote #(.B(B)) rem (.clk_sys(clk_sys), .line_to_dut(serial_in_line), .line_from_dut(serial_out_line));
  task automatic chk_msg(input rcsl_pkg::rcsl_msg_t got, input rcsl_pkg::rcsl_msg_t exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t message %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic put_tx(input rcsl_pkg::rcsl_msg_t m);
    for (int k = 0; k < 100 && tx_ready_q !== 1'b1; k++) @(negedge clk_sys);
    tx_msg = m;
    tx_valid = 1'b1;
    @(negedge clk_sys);
    tx_valid = 1'b0;
  endtask
  task automatic wait_rx(input int cnt);
    for (int k = 0; k < 8000 && rem.rxq.size() < cnt; k++) @(negedge clk_sys);
  endtask
  task automatic rx_msg(input rcsl_pkg::rcsl_msg_t m, input logic bad);
    rem.send_msg(m, bad);
    repeat (12) @(negedge clk_sys);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // about 16k cycles are needed; the margin covers a stalled serializer
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
  always @(posedge clk_sys) if (new_msg_q === 1'b1) pulses++;
  initial begin
    rst = 1'b1;
    tx_msg = 16'h0000;
    tx_valid = 1'b0;
    standby_lamp = 1'b0;
    carrier_detect = 1'b1;
    cfg_force_txoff = 1'b0;
    cfg_force_ilock = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    foreach (rows[i]) begin
      standby_lamp = rows[i].lamp;
      put_tx(rows[i].m);
      wait_rx(i + 1);
      chk_msg(rem.rxq[i], rows[i].exp_tx);
      p = pulses;
      rx_msg(rows[i].m, 1'b0);
      rx_msg(rows[i].m, 1'b0);
      chk_bit(pulses == p + 1, 1'b1);
      chk_msg(rx_msg_q, rows[i].m);
      chk_bit(txoff_q, rows[i].m.lo[0]);
    end
    p = pulses;
    rx_msg(16'h1111, 1'b0);
    rx_msg(16'h2222, 1'b0);
    chk_bit(pulses == p, 1'b1);
    rx_msg(16'h2222, 1'b0);
    rx_msg(16'h2222, 1'b0);
    chk_bit(pulses == p + 1, 1'b1);
    chk_msg(rx_msg_q, 16'h2222);
    rx_msg(16'h0C0C, 1'b0);
    rx_msg(16'h0C0C, 1'b1);
    chk_bit(pulses == p + 1, 1'b1);
    rx_msg(16'h0C0C, 1'b0);
    rx_msg(16'h0C0C, 1'b0);
    chk_bit(pulses == p + 2, 1'b1);
    carrier_detect = 1'b0;
    repeat (TO + 20) @(negedge clk_sys);
    chk_bit(timeout_q, 1'b1);
    chk_bit(txoff_q, 1'b0);
    cfg_force_txoff = 1'b1;
    cfg_force_ilock = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk_bit(txoff_q, 1'b1);
    chk_bit(ilock_q, 1'b1);
    carrier_detect = 1'b1;
    rx_msg(16'h5500, 1'b0);
    rx_msg(16'h5500, 1'b0);
    chk_bit(timeout_q, 1'b0);
    chk_bit(txoff_q, 1'b0);
    standby_lamp = 1'b0;
    rem.rxq.delete();
    n = 0;
    while (tx_ready_q === 1'b1 && n < 40) begin
      tx_msg = {8'h5A, 8'(n)};
      tx_valid = 1'b1;
      @(negedge clk_sys);
      tx_valid = 1'b0;
      @(negedge clk_sys);
      n++;
    end
    chk_bit(tx_ready_q, 1'b0);
    wait_rx(n);
    chk_bit(rem.rxq.size() == n, 1'b1);
    foreach (rem.rxq[i]) chk_msg(rem.rxq[i], {8'h5A, 8'(i)});
    chk_bit(rem.bad_cnt == 0, 1'b1);
    results();
  end
endmodule
